// [hdl/cocr_regs.sv]
// clock output control register bank with glitch-free output gating
`timescale 1ns/1ns
module cocr_regs
    import cocr_pkg::*;
#(
    parameter logic [3:0] MAKER_ID = 4'hA,  // value is arbitrary
    parameter logic [3:0] REVISION_ID = 4'h0  // value is arbitrary
)
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire cocr_req_t i_req,
    input wire logic i_soft_stop_n,
    input wire logic i_link_clk,
    input wire logic i_stop_pin_n,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output cocr_trim_t o_trim,
    output logic o_pci_stop,
    output cocr_gate_t o_gate,
    output logic o_proc_true_force_high,
    output logic o_proc_comp_drive_n
);

    // host-clock state
    typedef struct packed {
        logic [7:0] fixed_pci_and_48m_enables_reg;
        logic [7:0] clock_66m_output_enables_reg;
        logic [7:0] edge_rate_delay_trim_reg;
        logic [7:0] rdata_reg;
        logic rvalid_reg;
        logic pin_meta_reg;
        logic pin_sync_reg;
        logic stop_reg;
        cocr_trim_t trim_reg;
    } cocr_host_st_t;

    // link-clock state
    typedef struct packed {
        logic stop_meta_reg;
        logic stop_sync_reg;
        logic [2:0] stoppable_meta_reg;
        logic [2:0] stoppable_sync_reg;
        cocr_gate_t en_meta_reg;
        cocr_gate_t en_sync_reg;
        cocr_gate_t gate_reg;
        logic proc_hi_reg;
        logic proc_off_n_reg;
    } cocr_link_st_t;

    cocr_host_st_t h_reg;
    cocr_host_st_t h_next;
    cocr_link_st_t l_reg;
    cocr_link_st_t l_next;
    logic proc_en;

    // masked byte write for mixed-access registers
    function automatic logic [7:0] cocr_mwr(input logic [7:0] old, input logic [7:0] wd,
                                            input logic [7:0] mask);
        cocr_mwr = (old & ~mask) | (wd & mask);
    endfunction

    // the proc pair is not gated by these bytes; kept running
    assign proc_en = 1'b1;

    // host side: decode, read mux, stop request
    always_comb
    begin
        h_next = h_reg;
        h_next.rvalid_reg = 1'b0;
        h_next.pin_meta_reg = i_stop_pin_n;
        h_next.pin_sync_reg = h_reg.pin_meta_reg;
        h_next.stop_reg = ~h_reg.pin_sync_reg | ~i_soft_stop_n;
        if (i_req.wr)
        begin
            if (i_req.addr == ADDR_FIXED_PCI_48M)
            begin
                h_next.fixed_pci_and_48m_enables_reg = i_req.wdata;
            end
            else if (i_req.addr == ADDR_CLK66_EN)
            begin
                h_next.clock_66m_output_enables_reg =
                    cocr_mwr(h_reg.clock_66m_output_enables_reg, i_req.wdata,
                             WMASK_CLK66_EN);
            end
            else if (i_req.addr == ADDR_TRIM)
            begin
                h_next.edge_rate_delay_trim_reg =
                    cocr_mwr(h_reg.edge_rate_delay_trim_reg, i_req.wdata,
                             WMASK_TRIM);
            end
            // id byte and unmapped addresses ignore writes
        end
        if (i_req.rd)
        begin
            h_next.rvalid_reg = 1'b1;
            if (i_req.addr == ADDR_FIXED_PCI_48M)
            begin
                h_next.rdata_reg = h_reg.fixed_pci_and_48m_enables_reg;
            end
            else if (i_req.addr == ADDR_CLK66_EN)
            begin
                h_next.rdata_reg = h_reg.clock_66m_output_enables_reg;
            end
            else if (i_req.addr == ADDR_TRIM)
            begin
                h_next.rdata_reg = h_reg.edge_rate_delay_trim_reg;
            end
            else if (i_req.addr == ADDR_ID)
            begin
                h_next.rdata_reg = {REVISION_ID, MAKER_ID};
            end
            else
            begin
                h_next.rdata_reg = 8'h00;
            end
        end
        // trim fields driven to the analog side
        h_next.trim_reg.usb_edge =
            h_reg.edge_rate_delay_trim_reg[POS_USB_EDGE +: 2];
        h_next.trim_reg.disp_edge =
            h_reg.edge_rate_delay_trim_reg[POS_DISP_EDGE +: 2];
        h_next.trim_reg.buf_delay =
            h_reg.edge_rate_delay_trim_reg[POS_BUF_DELAY +: 2];
    end

    // power-on defaults; reset is the only register-level reset
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            h_reg <= '0;
            h_reg.fixed_pci_and_48m_enables_reg <= RST_FIXED_PCI_48M;
            h_reg.clock_66m_output_enables_reg <= RST_CLK66_EN;
            h_reg.edge_rate_delay_trim_reg <= RST_TRIM;
            h_reg.pin_meta_reg <= 1'b1;
            h_reg.pin_sync_reg <= 1'b1;
        end
        else if (i_ce)
        begin
            h_reg <= h_next;
        end
    end

    // link side: enables are quasi-static levels, so two flops suffice;
    // the rare multi-bit skew only delays a gate by one link edge
    always_comb
    begin
        l_next = l_reg;
        // stop level and stoppable selects cross on flop pairs of their own
        l_next.stop_meta_reg = h_reg.stop_reg;
        l_next.stop_sync_reg = l_reg.stop_meta_reg;
        l_next.stoppable_meta_reg =
            h_reg.fixed_pci_and_48m_enables_reg[POS_PCI_STOPPABLE +: 3];
        l_next.stoppable_sync_reg = l_reg.stoppable_meta_reg;
        l_next.en_meta_reg.fixed_pci = h_reg.fixed_pci_and_48m_enables_reg[POS_PCI_EN +: 3];
        l_next.en_meta_reg.usb_48m = h_reg.fixed_pci_and_48m_enables_reg[POS_USB_EN];
        l_next.en_meta_reg.display_48m = h_reg.fixed_pci_and_48m_enables_reg[POS_DISP_EN];
        l_next.en_meta_reg.clk66 = h_reg.clock_66m_output_enables_reg[5:0];
        l_next.en_meta_reg.proc = proc_en;
        l_next.en_sync_reg = l_reg.en_meta_reg;
        l_next.gate_reg = l_reg.en_sync_reg;
        // stop applied after the crossing: no gate built from two domains
        l_next.gate_reg.fixed_pci = l_reg.en_sync_reg.fixed_pci &
            ~(l_reg.stoppable_sync_reg & {3{l_reg.stop_sync_reg}});
        l_next.proc_hi_reg = ~l_reg.en_sync_reg.proc;
        l_next.proc_off_n_reg = l_reg.en_sync_reg.proc;
    end

    // gating flops update on the falling link edge, while clock is low
    always_ff @(negedge i_link_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            l_reg <= '0;
            l_reg.gate_reg <= '1;
            l_reg.en_meta_reg <= '1;
            l_reg.en_sync_reg <= '1;
            l_reg.proc_off_n_reg <= 1'b1;
        end
        else
        begin
            l_reg <= l_next;
        end
    end

    assign o_rdata = h_reg.rdata_reg;
    assign o_rvalid = h_reg.rvalid_reg;
    assign o_trim = h_reg.trim_reg;
    assign o_pci_stop = h_reg.stop_reg;
    assign o_gate = l_reg.gate_reg;
    assign o_proc_true_force_high = l_reg.proc_hi_reg;
    assign o_proc_comp_drive_n = l_reg.proc_off_n_reg;

    // read-only id ignores writes
    property p_id_fixed;
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && i_req.rd && i_req.addr == ADDR_ID) |=>
            (o_rdata == {REVISION_ID, MAKER_ID} && o_rvalid);
    endproperty
    a_id_fixed: assert property (p_id_fixed) else $error("id byte wrong");

    // reserved bits of clk66 byte stay zero
    property p_clk66_resv;
        @(posedge i_clk) disable iff (i_reset)
        h_reg.clock_66m_output_enables_reg[7:6] == 2'b00;
    endproperty
    a_clk66_resv: assert property (p_clk66_resv) else $error("reserved bits set");

    // trim reserved bits stay zero
    property p_trim_resv;
        @(posedge i_clk) disable iff (i_reset)
        h_reg.edge_rate_delay_trim_reg[7:6] == 2'b00;
    endproperty
    a_trim_resv: assert property (p_trim_resv) else $error("trim reserved set");

    // byte-3 write stored
    property p_b3_store;
        logic [7:0] d;
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && i_req.wr && i_req.addr == ADDR_FIXED_PCI_48M, d = i_req.wdata) |=>
            h_reg.fixed_pci_and_48m_enables_reg == d;
    endproperty
    a_b3_store: assert property (p_b3_store) else $error("byte 3 not stored");

    // stop request follows a low soft stop bit one cycle later
    property p_stop;
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && !i_soft_stop_n) |=> o_pci_stop;
    endproperty
    a_stop: assert property (p_stop) else $error("soft stop missed");

    // usb edge trim follows stored field
    property p_usb_edge;
        @(posedge i_clk) disable iff (i_reset)
        i_ce |=> o_trim.usb_edge == $past(h_reg.edge_rate_delay_trim_reg[1:0]);
    endproperty
    a_usb_edge: assert property (p_usb_edge) else $error("usb trim wrong");

    // gate seen at each rising link edge; a different value at the next
    // falling edge would mean the gate moved while the clock was high
    cocr_gate_t gate_hi_reg;
    always_ff @(posedge i_link_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            gate_hi_reg <= '1;
        end
        else
        begin
            gate_hi_reg <= o_gate;
        end
    end

    // gate holds through the high phase of the link clock
    property p_gate_stable;
        @(negedge i_link_clk) disable iff (i_reset)
        o_gate == gate_hi_reg;
    endproperty
    a_gate_stable: assert property (p_gate_stable) else $error("gate changed high");

    // enable held low across the three link stages plus the sample
    sequence s_clk66_0_off_held;
        (!h_reg.clock_66m_output_enables_reg[0])[*4];
    endsequence

    // disabled enable reaches gate within link sync latency
    property p_gate_off;
        @(negedge i_link_clk) disable iff (i_reset)
        s_clk66_0_off_held |-> !o_gate.clk66[0];
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("gate not off");

    // read answer is a one-cycle pulse one edge after the request
    property p_read_pulse;
        @(posedge i_clk) disable iff (i_reset)
        i_ce |=> o_rvalid == $past(i_req.rd);
    endproperty
    a_read_pulse: assert property (p_read_pulse) else $error("read pulse wrong");

    // clk66 byte keeps only its writable bits
    property p_b4_store;
        logic [7:0] d;
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && i_req.wr && i_req.addr == ADDR_CLK66_EN, d = i_req.wdata) |=>
            h_reg.clock_66m_output_enables_reg == (d & WMASK_CLK66_EN);
    endproperty
    a_b4_store: assert property (p_b4_store) else $error("byte 4 not stored");

    // trim byte keeps only its writable bits
    property p_trim_store;
        logic [7:0] d;
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && i_req.wr && i_req.addr == ADDR_TRIM, d = i_req.wdata) |=>
            h_reg.edge_rate_delay_trim_reg == (d & WMASK_TRIM);
    endproperty
    a_trim_store: assert property (p_trim_store) else $error("trim not stored");

    // pin low through both synchroniser flops and the stop flop
    sequence s_pin_low_held;
        (i_ce && !i_stop_pin_n)[*3];
    endsequence

    property p_pin_stop;
        @(posedge i_clk) disable iff (i_reset)
        s_pin_low_held |=> o_pci_stop;
    endproperty
    a_pin_stop: assert property (p_pin_stop) else $error("pin stop missed");

    // stoppable output 0 under a standing stop request
    sequence s_pci0_stop_held;
        (h_reg.stop_reg && h_reg.fixed_pci_and_48m_enables_reg[POS_PCI_STOPPABLE])[*4];
    endsequence

    property p_stoppable_off;
        @(negedge i_link_clk) disable iff (i_reset)
        s_pci0_stop_held |-> !o_gate.fixed_pci[0];
    endproperty
    a_stoppable_off: assert property (p_stoppable_off) else $error("stop not applied");

    // enabled free-running output 1 ignores any stop request
    sequence s_pci1_free_held;
        (h_reg.fixed_pci_and_48m_enables_reg[POS_PCI_EN + 1] &&
         !h_reg.fixed_pci_and_48m_enables_reg[POS_PCI_STOPPABLE + 1])[*4];
    endsequence

    property p_free_run;
        @(negedge i_link_clk) disable iff (i_reset)
        s_pci1_free_held |-> o_gate.fixed_pci[1];
    endproperty
    a_free_run: assert property (p_free_run) else $error("free run output stopped");

endmodule // cocr_regs

// [hdl/cocr_pkg.sv]
// package for the clock output control register bank
package cocr_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_FIXED_PCI_48M = 8'h03;
    localparam logic [7:0] ADDR_CLK66_EN = 8'h04;
    localparam logic [7:0] ADDR_TRIM = 8'h05;
    localparam logic [7:0] ADDR_ID = 8'h06;
    // power-on defaults
    localparam logic [7:0] RST_FIXED_PCI_48M = 8'hC7;
    localparam logic [7:0] RST_CLK66_EN = 8'h3F;
    localparam logic [7:0] RST_TRIM = 8'h00;
    // writable masks
    localparam logic [7:0] WMASK_CLK66_EN = 8'h3F;
    localparam logic [7:0] WMASK_TRIM = 8'h3F;
    // field positions in the byte-3 register
    localparam int POS_PCI_EN = 0;
    localparam int POS_PCI_STOPPABLE = 3;
    localparam int POS_USB_EN = 6;
    localparam int POS_DISP_EN = 7;
    // field positions in the trim register
    localparam int POS_USB_EDGE = 0;
    localparam int POS_DISP_EDGE = 2;
    localparam int POS_BUF_DELAY = 4;

    // register read or write request from the management host
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cocr_req_t;

    // gating enables for the single-ended outputs and the proc pair
    typedef struct packed {
        logic [2:0] fixed_pci;
        logic usb_48m;
        logic display_48m;
        logic [5:0] clk66;
        logic proc;
    } cocr_gate_t;

    // trim settings
    typedef struct packed {
        logic [1:0] usb_edge;
        logic [1:0] disp_edge;
        logic [1:0] buf_delay;
    } cocr_trim_t;
endpackage

// [dv/cocr_host.sv]
// management host model driving the register port and stop controls
`timescale 1ns/1ns
module cocr_host
    import cocr_pkg::*;
(
    input wire logic i_clk,
    output cocr_req_t o_req,
    output logic o_soft_stop_n,
    output logic o_stop_pin_n
);
    // idle host: no request, no stop
    initial
    begin
        o_req = '0;
        o_soft_stop_n = 1'b1;
        o_stop_pin_n = 1'b1;
    end
    // one byte per access; idle address and data are inverted so stale values never match
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge i_clk);
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // never both stop methods low at once
    task automatic set_stop(input logic pin_n, input logic soft_n);
        @(negedge i_clk);
        o_stop_pin_n = pin_n;
        o_soft_stop_n = pin_n ? soft_n : 1'b1;
    endtask
endmodule // cocr_host

// [dv/test_clock_output_control_regs.sv]
// self-checking bench for the clock output control register bank
`timescale 1ns/1ns
module test_clock_output_control_regs;
    import cocr_pkg::*;
    localparam logic [7:0] ID = 8'h95;
    logic i_clk = 1'b0;
    logic i_link_clk = 1'b0;
    logic i_reset = 1'b0;
    logic ce = 1'b1;
    cocr_req_t req;
    logic soft_n, pin_n, rvalid, pci_stop, force_high, comp_n;
    logic [7:0] rdata;
    logic [7:0] lf = 8'h2C;
    cocr_trim_t trim;
    cocr_gate_t gate;
    logic [7:0] exp_q[$];
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    // host clock and an unrelated link clock
    initial
        forever #10 i_clk = ~i_clk;
    initial
    begin
        #7;
        forever #40 i_link_clk = ~i_link_clk;
    end
    cocr_host host (.i_clk(i_clk), .o_req(req), .o_soft_stop_n(soft_n), .o_stop_pin_n(pin_n));
    cocr_regs #(.MAKER_ID(4'h5), .REVISION_ID(4'h9)) dut (
        .i_clk(i_clk), .i_reset(i_reset), .i_ce(ce), .i_req(req), .i_soft_stop_n(soft_n),
        .i_link_clk(i_link_clk), .i_stop_pin_n(pin_n), .o_rdata(rdata), .o_rvalid(rvalid),
        .o_trim(trim), .o_pci_stop(pci_stop), .o_gate(gate),
        .o_proc_true_force_high(force_high), .o_proc_comp_drive_n(comp_n));
    // compare helpers
    task automatic check_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check_bits(input string n, input logic [11:0] e, input logic [11:0] g);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // note the expected byte, then issue the read
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.access(1'b0, a, 8'h00);
    endtask
    // gating crosses domains, so give it several link edges
    task automatic settle;
        repeat (6) @(negedge i_link_clk);
        @(negedge i_clk);
    endtask
    // read results matched against the oldest note
    always @(negedge i_clk)
        if (rvalid === 1'b1)
        begin
            if (exp_q.size() == 0)
                check_byte("read_queue", 8'h00, 8'hFF);
            else
                check_byte("read_data", exp_q.pop_front(), rdata);
        end
    // a gate change on a high clock would clip a pulse
    always @(gate)
        if (i_reset === 1'b0)
            check_bits("gate_link_low", 12'h000, {11'h0, i_link_clk});
    // hang guard
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            final_report;
        end
    end
    initial
    begin
        // raised after time zero so the asynchronous reset sees an edge
        #1 i_reset = 1'b1;
        repeat (5) @(posedge i_clk);
        @(negedge i_clk) i_reset = 1'b0;
        rd(ADDR_FIXED_PCI_48M, 8'hC7);
        rd(ADDR_CLK66_EN, 8'h3F);
        rd(ADDR_TRIM, 8'h00);
        rd(ADDR_ID, ID);
        host.access(1'b1, ADDR_ID, 8'h00);
        rd(ADDR_ID, ID);
        host.access(1'b1, ADDR_CLK66_EN, 8'hFF);
        rd(ADDR_CLK66_EN, 8'h3F);
        host.access(1'b1, ADDR_TRIM, 8'hE4);
        rd(ADDR_TRIM, 8'h24);
        check_bits("trim", {6'h0, 6'b00_01_10}, {6'h0, trim});
        rd(8'h07, 8'h00);
        // random trim values read back with reserved bits cleared
        repeat (4)
        begin
            lf = lfsr(lf);
            host.access(1'b1, ADDR_TRIM, lf);
            rd(ADDR_TRIM, lf & 8'h3F);
        end
        // frozen host side ignores a write
        @(negedge i_clk) ce = 1'b0;
        host.access(1'b1, ADDR_TRIM, ~lf);
        @(negedge i_clk) ce = 1'b1;
        rd(ADDR_TRIM, lf & 8'h3F);
        host.access(1'b1, ADDR_FIXED_PCI_48M, 8'h00);
        host.access(1'b1, ADDR_CLK66_EN, 8'h00);
        settle;
        check_bits("gate_off", 12'h001, gate);
        check_bits("proc_legs", 12'h001, {10'h0, force_high, comp_n});
        host.access(1'b1, ADDR_FIXED_PCI_48M, 8'h0F);
        // pin stop, then software stop; only output 0 is stoppable
        for (int i = 0; i < 2; i++)
        begin
            host.set_stop(i[0], !i[0]);
            settle;
            check_bits("pci_stop", 12'h001, {11'h0, pci_stop});
            check_bits("gate_stop", 12'hC01, gate);
        end
        host.set_stop(1'b1, 1'b1);
        settle;
        check_bits("gate_run", 12'hE01, gate);
        check_bits("pci_run", 12'h000, {11'h0, pci_stop});
        // second reset restores defaults
        @(negedge i_clk) i_reset = 1'b1;
        @(negedge i_clk) i_reset = 1'b0;
        rd(ADDR_FIXED_PCI_48M, 8'hC7);
        repeat (4) @(negedge i_clk);
        check_bits("reads_left", 12'h000, 12'(exp_q.size()));
        final_report;
    end
endmodule // test_clock_output_control_regs
